// [common/emu_probe_pkg.sv]
// constants and types shared by the emulator probe run-control block
// assumes a 32-bit classic wishbone slave and a 20-bit linear address space
package emu_probe_pkg;
    localparam int          ADDR_W         = 20;
    localparam int          ASYNC_N        = 6;
    // register byte offsets
    localparam logic [7:0]  OFS_CTRL       = 8'h00;
    localparam logic [7:0]  OFS_STAT       = 8'h04;
    localparam logic [7:0]  OFS_IRQ_STAT   = 8'h08;
    localparam logic [7:0]  OFS_IRQ_MASK   = 8'h0C;
    localparam logic [7:0]  OFS_BRK_ADDR   = 8'h10;
    localparam logic [7:0]  OFS_LAST_ADDR  = 8'h14;
    localparam logic [7:0]  OFS_NEXT_ADDR  = 8'h18;
    // control bits
    localparam int          CTL_COMB_RDY   = 0;
    localparam int          CTL_STEP       = 1;
    localparam int          CTL_MEM_TMO    = 2;
    localparam int          CTL_BRK_EN     = 3;
    localparam int          CTL_COP_IEN    = 4;
    localparam int          CTL_EMU_REQ    = 5;
    localparam int          CTL_W          = 6;
    localparam logic [5:0]  CTL_RESET      = 6'h04;
    // interrupt status bits
    localparam int          IRQ_BRK        = 0;
    localparam int          IRQ_SYNC       = 1;
    localparam int          IRQ_COP        = 2;
    localparam int          IRQ_WRAP       = 3;
    localparam int          IRQ_W          = 4;
    // synchronised input positions
    localparam int          AS_SYNC_N      = 0;
    localparam int          AS_USER_RDY    = 1;
    localparam int          AS_NMI         = 2;
    localparam int          AS_INTR        = 3;
    localparam int          AS_COP_REQ     = 4;
    localparam int          AS_COP_EXC     = 5;
    localparam logic [5:0]  AS_IDLE        = 6'h01;
    localparam logic [15:0] OFF_MAX        = 16'hFFFF;
    localparam logic [19:0] ADDR_ONE       = 20'h00001;

    typedef enum logic [1:0] {
        SVC_IDLE      = 2'b00,
        SVC_INTR_HEAD = 2'b01,
        SVC_NMI       = 2'b10,
        SVC_INTR_TAIL = 2'b11
    } svc_state_t;

    typedef struct packed {
        logic [19:0] last_addr;
        logic [19:0] next_addr;
    } brk_report_t;
endpackage

// [hw/emu_run_control.sv]
// run control of an emulator probe: ready gating, start sync, interrupt order,
// coprocessor gating, linear trace address and break recognition
// assumes pins other than probe_ready, t1, t2 and the cpu strobes are asynchronous
//
// Chosen here: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - with combined ready selected, cpu ready is user ready AND probe ready.
// - with combined ready selected, probe ready not caught at T2 counts as false for that cycle.
// - NMI with INTR: INTR head first, then NMI, then INTR remainder.
// - NMI requests are ignored while single instruction stepping.
// - the start sync input is active low and idles high.
// - sync low at emulation entry holds cpu ready low, stalling the cpu.
// - emulation waits for sync high; its rise releases ready.
// - coprocessor bus requests are not granted while sync is low.
// - coprocessor exception output rises on unmasked exception when enabled.
// - trace address is 20-bit linear, offset FFFF plus one gives 10000H.
// - address mismatch flagged only when the offset steps past its maximum.
// - a break fires right after the target instruction completes.
// - break records last executed and next instruction addresses.
// - breaks inside combined instructions wait until the combination ends.
// - primitive operations of wait and string instructions may break mid-way.
module emu_run_control (
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             irq_o,
    input  wire logic        sync_start_n_i,
    input  wire logic        user_ready_i,
    input  wire logic        probe_ready_i,
    input  wire logic        t1_i,
    input  wire logic        t2_i,
    output logic             cpu_ready_o,
    output logic             stall_o,
    output logic             emulating_o,
    output logic             mem_timeout_en_o,
    input  wire logic        cop_req_i,
    output logic             cop_grant_o,
    input  wire logic        cop_exc_i,
    output logic             cop_exc_o,
    input  wire logic        nmi_i,
    input  wire logic        intr_i,
    input  wire logic        vector_done_i,
    input  wire logic        nmi_done_i,
    input  wire logic        intr_done_i,
    output logic             serve_intr_o,
    output logic             serve_nmi_o,
    input  wire logic [15:0] seg_i,
    input  wire logic [15:0] off_i,
    input  wire logic        addr_load_i,
    input  wire logic        addr_inc_i,
    output logic      [19:0] trace_addr_o,
    output logic             wrap_mismatch_o,
    input  wire logic        instr_end_i,
    input  wire logic        combined_i,
    input  wire logic        prim_op_i,
    input  wire logic [19:0] next_addr_i,
    output logic             break_o
);
    localparam int N = emu_probe_pkg::ASYNC_N;

    logic [N-1:0]                 meta_r;
    logic [N-1:0]                 sync_r;
    logic [N-1:0]                 async_in;
    logic [emu_probe_pkg::CTL_W-1:0] ctrl_r;
    logic [emu_probe_pkg::IRQ_W-1:0] irq_stat_r;
    logic [emu_probe_pkg::IRQ_W-1:0] irq_mask_r;
    logic [emu_probe_pkg::IRQ_W-1:0] irq_set;
    logic [19:0]                  brk_addr_r;
    emu_probe_pkg::brk_report_t   report_r;
    logic                         sync_hi_d_r;
    logic                         emu_req_d_r;
    logic                         probe_cap_r;
    logic                         stall_r;
    logic                         nmi_d_r;
    logic                         nmi_pend_r;
    logic                         resume_intr_r;
    emu_probe_pkg::svc_state_t    svc_r;
    emu_probe_pkg::svc_state_t    svc_nxt;
    logic [19:0]                  lin_r;
    logic [15:0]                  off_r;
    logic                         wrap_r;
    logic                         brk_pend_r;
    logic                         brk_r;
    logic                         cop_exc_r;
    logic                         sync_hi;
    logic                         sync_rise;
    logic                         emu_entry;
    logic                         nmi_rise;
    logic                         brk_match;
    logic                         brk_fire;
    logic                         wrap_step;
    logic                         bus_req;
    logic                         bus_wr;
    logic [31:0]                  wmask;
    logic [31:0]                  wdata;

    function automatic logic [31:0] lane_mask(input logic [3:0] sel);
        lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction

    // applies byte enables to a stored word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] m,
                                          input logic [31:0] d);
        merge = (old & ~m) | (d & m);
    endfunction

    // two-flop synchronisers; only the second stage is read anywhere
    assign async_in = {cop_exc_i, cop_req_i, intr_i, nmi_i, user_ready_i, sync_start_n_i};
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_sync
            always_ff @(posedge clock_i or posedge rst_i) begin
                if (rst_i) begin
                    meta_r[g] <= emu_probe_pkg::AS_IDLE[g];
                    sync_r[g] <= emu_probe_pkg::AS_IDLE[g];
                end else if (ce_i) begin
                    meta_r[g] <= async_in[g];
                    sync_r[g] <= meta_r[g];
                end
            end
        end
    endgenerate

    assign sync_hi   = sync_r[emu_probe_pkg::AS_SYNC_N];
    assign sync_rise = sync_hi & ~sync_hi_d_r;
    assign emu_entry = ctrl_r[emu_probe_pkg::CTL_EMU_REQ] & ~emu_req_d_r;
    assign nmi_rise  = sync_r[emu_probe_pkg::AS_NMI] & ~nmi_d_r;

    // wishbone slave, one wait state, every address answered
    assign bus_req = wb_cyc_i & wb_stb_i;
    assign bus_wr  = bus_req & wb_we_i & ~wb_ack_o;
    assign wmask   = lane_mask(wb_sel_i);
    assign wdata   = wb_dat_i & wmask;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else if (ce_i) begin
            wb_ack_o <= bus_req & ~wb_ack_o;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (ce_i) begin
            case (wb_adr_i)
                emu_probe_pkg::OFS_CTRL:      wb_dat_o <= 32'(ctrl_r);
                emu_probe_pkg::OFS_STAT:      wb_dat_o <= 32'({nmi_pend_r, serve_nmi_o,
                                                  serve_intr_o, emulating_o, stall_r, sync_hi});
                emu_probe_pkg::OFS_IRQ_STAT:  wb_dat_o <= 32'(irq_stat_r);
                emu_probe_pkg::OFS_IRQ_MASK:  wb_dat_o <= 32'(irq_mask_r);
                emu_probe_pkg::OFS_BRK_ADDR:  wb_dat_o <= 32'(brk_addr_r);
                emu_probe_pkg::OFS_LAST_ADDR: wb_dat_o <= 32'(report_r.last_addr);
                emu_probe_pkg::OFS_NEXT_ADDR: wb_dat_o <= 32'(report_r.next_addr);
                default:                      wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_r     <= emu_probe_pkg::CTL_RESET;
            irq_mask_r <= '0;
            brk_addr_r <= '0;
        end else if (ce_i && bus_wr) begin
            case (wb_adr_i)
                emu_probe_pkg::OFS_CTRL:
                    ctrl_r <= emu_probe_pkg::CTL_W'(merge(32'(ctrl_r), wmask, wb_dat_i));
                emu_probe_pkg::OFS_IRQ_MASK:
                    irq_mask_r <= emu_probe_pkg::IRQ_W'(merge(32'(irq_mask_r), wmask, wb_dat_i));
                emu_probe_pkg::OFS_BRK_ADDR:
                    brk_addr_r <= 20'(merge(32'(brk_addr_r), wmask, wb_dat_i));
                default: ;
            endcase
        end
    end

    // sticky events; a new event beats a clear in the same cycle
    assign irq_set = {wrap_step, cop_exc_o & ~cop_exc_r, sync_rise & stall_r, brk_fire};

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            irq_stat_r <= '0;
        end else if (ce_i) begin
            if (bus_wr && wb_adr_i == emu_probe_pkg::OFS_IRQ_STAT) begin
                irq_stat_r <= (irq_stat_r & ~emu_probe_pkg::IRQ_W'(wdata)) | irq_set;
            end else begin
                irq_stat_r <= irq_stat_r | irq_set;
            end
        end
    end

    assign irq_o            = |(irq_stat_r & irq_mask_r);
    assign mem_timeout_en_o = ctrl_r[emu_probe_pkg::CTL_MEM_TMO];

    // ready path: probe ready is caught at T2 and dropped at T1
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            probe_cap_r <= 1'b0;
        end else if (ce_i) begin
            if (t2_i) begin
                probe_cap_r <= probe_ready_i;
            end else if (t1_i) begin
                probe_cap_r <= 1'b0;
            end
        end
    end

    // start stall; entry is the rise of the emulation request bit
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            stall_r     <= 1'b0;
            sync_hi_d_r <= 1'b1;
            emu_req_d_r <= 1'b0;
        end else if (ce_i) begin
            sync_hi_d_r <= sync_hi;
            emu_req_d_r <= ctrl_r[emu_probe_pkg::CTL_EMU_REQ];
            if (emu_entry && !sync_hi) begin
                stall_r <= 1'b1;
            end else if (sync_hi || !ctrl_r[emu_probe_pkg::CTL_EMU_REQ]) begin
                stall_r <= 1'b0;
            end
        end
    end

    always_comb begin
        if (stall_r) begin
            cpu_ready_o = 1'b0;
        end else if (ctrl_r[emu_probe_pkg::CTL_COMB_RDY]) begin
            cpu_ready_o = sync_r[emu_probe_pkg::AS_USER_RDY] & probe_cap_r;
        end else begin
            cpu_ready_o = probe_ready_i;
        end
    end

    assign stall_o     = stall_r;
    assign emulating_o = ctrl_r[emu_probe_pkg::CTL_EMU_REQ] & ~stall_r & sync_hi;
    assign cop_grant_o = sync_r[emu_probe_pkg::AS_COP_REQ] & sync_hi;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            cop_exc_r <= 1'b0;
            cop_exc_o <= 1'b0;
        end else if (ce_i) begin
            cop_exc_r <= cop_exc_o;
            cop_exc_o <= sync_r[emu_probe_pkg::AS_COP_EXC] & ctrl_r[emu_probe_pkg::CTL_COP_IEN];
        end
    end

    // interrupt ordering; nmi edges outside stepping set one pending bit, served once a busy sequence allows
    always_comb begin
        svc_nxt = svc_r;
        case (svc_r)
            emu_probe_pkg::SVC_IDLE: begin
                if (sync_r[emu_probe_pkg::AS_INTR]) begin
                    svc_nxt = emu_probe_pkg::SVC_INTR_HEAD;
                end else if (nmi_pend_r) begin
                    svc_nxt = emu_probe_pkg::SVC_NMI;
                end
            end
            emu_probe_pkg::SVC_INTR_HEAD: begin
                if (vector_done_i) begin
                    svc_nxt = nmi_pend_r ? emu_probe_pkg::SVC_NMI
                                         : emu_probe_pkg::SVC_INTR_TAIL;
                end
            end
            emu_probe_pkg::SVC_NMI: begin
                if (nmi_done_i) begin
                    svc_nxt = resume_intr_r ? emu_probe_pkg::SVC_INTR_TAIL
                                            : emu_probe_pkg::SVC_IDLE;
                end
            end
            emu_probe_pkg::SVC_INTR_TAIL: begin
                if (intr_done_i) begin
                    svc_nxt = emu_probe_pkg::SVC_IDLE;
                end
            end
            default: svc_nxt = emu_probe_pkg::SVC_IDLE;
        endcase
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            svc_r         <= emu_probe_pkg::SVC_IDLE;
            resume_intr_r <= 1'b0;
        end else if (ce_i) begin
            svc_r <= svc_nxt;
            if (svc_r == emu_probe_pkg::SVC_INTR_HEAD && svc_nxt == emu_probe_pkg::SVC_NMI) begin
                resume_intr_r <= 1'b1;
            end else if (svc_nxt != emu_probe_pkg::SVC_NMI) begin
                resume_intr_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            nmi_d_r    <= 1'b0;
            nmi_pend_r <= 1'b0;
        end else if (ce_i) begin
            nmi_d_r <= sync_r[emu_probe_pkg::AS_NMI];
            if (nmi_rise && !ctrl_r[emu_probe_pkg::CTL_STEP]) begin
                nmi_pend_r <= 1'b1;
            end else if (svc_nxt == emu_probe_pkg::SVC_NMI && svc_r != emu_probe_pkg::SVC_NMI) begin
                nmi_pend_r <= 1'b0;
            end
        end
    end

    assign serve_nmi_o  = (svc_r == emu_probe_pkg::SVC_NMI);
    assign serve_intr_o = (svc_r == emu_probe_pkg::SVC_INTR_HEAD) ||
                          (svc_r == emu_probe_pkg::SVC_INTR_TAIL);

    // linear trace address; the cpu wraps its offset, this counter does not
    assign wrap_step = addr_inc_i & ~addr_load_i & (off_r == emu_probe_pkg::OFF_MAX);

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            lin_r  <= '0;
            off_r  <= '0;
            wrap_r <= 1'b0;
        end else if (ce_i) begin
            if (addr_load_i) begin
                lin_r  <= 20'({seg_i, 4'h0} + {4'h0, off_i});
                off_r  <= off_i;
                wrap_r <= 1'b0;
            end else if (addr_inc_i) begin
                lin_r  <= lin_r + emu_probe_pkg::ADDR_ONE;
                off_r  <= off_r + 16'h0001;
                wrap_r <= wrap_r | wrap_step;
            end
        end
    end

    assign trace_addr_o    = lin_r;
    assign wrap_mismatch_o = wrap_r;

    // break recognition
    assign brk_match = ctrl_r[emu_probe_pkg::CTL_BRK_EN] && (lin_r == brk_addr_r);
    assign brk_fire  = (instr_end_i & ~combined_i & (brk_match | brk_pend_r)) |
                       (prim_op_i & brk_match);

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            brk_pend_r <= 1'b0;
            brk_r      <= 1'b0;
            report_r   <= '0;
        end else if (ce_i) begin
            brk_r <= brk_fire;
            if (brk_fire) begin
                brk_pend_r         <= 1'b0;
                report_r.last_addr <= lin_r;
                report_r.next_addr <= next_addr_i;
            end else if (instr_end_i && combined_i && brk_match) begin
                brk_pend_r <= 1'b1;
            end
        end
    end

    assign break_o = brk_r;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    ready_combine_a: assert property (!stall_r && ctrl_r[emu_probe_pkg::CTL_COMB_RDY]
        |-> cpu_ready_o == (sync_r[emu_probe_pkg::AS_USER_RDY] && probe_cap_r))
        else $error("combined ready mismatch");
    t2_miss_a: assert property (ce_i && t1_i && !t2_i ##1 !t2_i
        |-> !probe_cap_r)
        else $error("probe ready held without t2 capture");
    intr_first_a: assert property (ce_i && svc_r == emu_probe_pkg::SVC_IDLE && nmi_pend_r
        && sync_r[emu_probe_pkg::AS_INTR] |=> svc_r == emu_probe_pkg::SVC_INTR_HEAD)
        else $error("nmi taken before intr");
    nmi_resume_a: assert property (ce_i && serve_nmi_o && nmi_done_i && resume_intr_r
        |=> svc_r == emu_probe_pkg::SVC_INTR_TAIL)
        else $error("intr not resumed after nmi");
    step_nmi_a: assert property (ce_i && ctrl_r[emu_probe_pkg::CTL_STEP] && !nmi_pend_r
        && !($rose(stall_r)) |=> !nmi_pend_r)
        else $error("nmi latched while stepping");
    stall_hold_a: assert property (ce_i && emu_entry && !sync_hi
        |=> !cpu_ready_o && stall_o)
        else $error("ready not held at stalled entry");
    sync_release_a: assert property (ce_i && stall_r && sync_hi
        |=> !stall_r)
        else $error("stall outlived sync rise");
    cop_withhold_a: assert property (!sync_hi |-> !cop_grant_o)
        else $error("coprocessor granted while sync low");
    cop_exc_a: assert property (ce_i && sync_r[emu_probe_pkg::AS_COP_EXC]
        && ctrl_r[emu_probe_pkg::CTL_COP_IEN] |=> cop_exc_o)
        else $error("coprocessor exception not raised");
    no_wrap_a: assert property (ce_i && addr_inc_i && !addr_load_i
        |=> trace_addr_o == 20'($past(trace_addr_o) + emu_probe_pkg::ADDR_ONE))
        else $error("trace address wrapped");
    wrap_flag_a: assert property (ce_i && !wrap_r && !(addr_inc_i && off_r == emu_probe_pkg::OFF_MAX)
        |=> !wrap_r || $past(addr_load_i))
        else $error("mismatch without offset overflow");
    brk_time_a: assert property (ce_i && instr_end_i && !combined_i && brk_match
        |=> break_o && report_r.last_addr == $past(lin_r))
        else $error("break not taken after target");
    combined_a: assert property (ce_i && instr_end_i && combined_i && brk_match && !prim_op_i
        |=> !break_o ##0 brk_pend_r)
        else $error("break inside combined instruction");
    prim_a: assert property (ce_i && prim_op_i && brk_match |=> break_o)
        else $error("primitive operation break missed");

    enter_stall_c: cover property (emu_entry && !sync_hi ##[1:50] sync_rise);
    nmi_inside_intr_c: cover property (serve_intr_o ##1 serve_nmi_o ##[1:50] serve_intr_o);
    slip_break_c: cover property (brk_pend_r ##[1:20] break_o);
    wrap_c: cover property (wrap_step);
endmodule

`default_nettype wire

// [dv/emu_bus_partner.sv]
// user prototype side of the processor bus: bus state pulses and user ready
// assumes a four clock bus cycle with T1 then T2
`timescale 1ns/1ps
`default_nettype none
module emu_bus_partner (
    input  wire logic clock_i,
    input  wire logic rst_i,
    input  wire logic slow_i,
    output logic      t1_o,
    output logic      t2_o,
    output logic      user_ready_o
);
    logic [1:0] phase_r;
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            phase_r      <= 2'h0;
            t1_o         <= 1'b0;
            t2_o         <= 1'b0;
            user_ready_o <= 1'b1;
        end else begin
            phase_r      <= phase_r + 2'h1;
            t1_o         <= (phase_r == 2'h3);
            t2_o         <= (phase_r == 2'h0);
            // slow prototype keeps ready low; no master chained on line one
            user_ready_o <= ~slow_i;
        end
    end
endmodule
`default_nettype wire

// [dv/emu_run_control_tb.sv]
// self-checking bench of the run-control block
// assumes the partner model drives the bus state pulses and user ready
`timescale 1ns/1ps
`default_nettype none
module emu_run_control_tb;
    logic        clock_i = 0, rst_i = 1, ce_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, seed = 32'h9023;
    logic        wb_ack_o, irq_o, sync_start_n_i = 1, user_ready_i, probe_ready_i = 0;
    logic        t1_i, t2_i, cpu_ready_o, stall_o, emulating_o, mem_timeout_en_o, slow = 0;
    logic        cop_req_i = 1, cop_grant_o, cop_exc_i = 0, cop_exc_o, nmi_i = 0, intr_i = 0;
    logic        serve_intr_o, serve_nmi_o, addr_load_i = 0, addr_inc_i = 0, wrap_mismatch_o;
    logic        combined_i = 0, break_o;
    logic [4:0]  dn = 5'h0;
    logic [15:0] seg_i = 16'h0, off_i = 16'h0;
    logic [19:0] trace_addr_o, next_addr_i = 20'h0, exp_a;
    logic [31:0] rdq[$];
    int          mismatches = 0, total_checks = 0, cycles = 0, i;
    wire         vector_done_i = dn[0], nmi_done_i = dn[1], intr_done_i = dn[2];
    wire         instr_end_i = dn[3], prim_op_i = dn[4];

    emu_run_control i_emu_run_control (.*);
    emu_bus_partner i_emu_bus_partner (.clock_i(clock_i), .rst_i(rst_i), .slow_i(slow),
        .t1_o(t1_i), .t2_o(t2_i), .user_ready_o(user_ready_i));

    always #2 clock_i = ~clock_i;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
    endfunction

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        @(posedge clock_i);
        while (wb_ack_o !== 1'b1) @(posedge clock_i);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    // expected read data goes to the queue, the monitor compares on ack
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rdq.push_back(e);
        wb(1'b0, a, 32'h0);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clock_i);
        @(negedge clock_i);
    endtask

    task automatic pulse(input int k);
        @(posedge clock_i);
        dn <= 5'(1 << k);
        @(posedge clock_i);
        dn <= 5'h0;
        @(negedge clock_i);
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge clock_i) begin
        cycles++;
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && rdq.size() > 0)
            chk("read data", rdq.pop_front(), wb_dat_o);
        if (cycles == 5000) begin
            mismatches++;
            test_done();
        end
    end

    initial begin
        repeat (8) @(posedge clock_i);
        rst_i <= 1'b0;
        rd(emu_probe_pkg::OFS_CTRL, 32'(emu_probe_pkg::CTL_RESET));
        rd(8'hFC, 32'h0);
        chk("mem timeout", 32'h1, 32'(mem_timeout_en_o));
        wb(1'b1, emu_probe_pkg::OFS_CTRL, 32'h01);
        for (i = 0; i < 3; i++) begin
            @(posedge clock_i);
            probe_ready_i <= (i != 0);
            slow <= (i == 2);
            repeat (5) @(posedge clock_i);
            while (t2_i !== 1'b1) @(posedge clock_i);
            @(negedge clock_i);
            chk("cpu ready", 32'(i == 1), 32'(cpu_ready_o));
        end
        @(posedge clock_i);
        slow <= 1'b0;
        $display("test ready done");
        sync_start_n_i <= 1'b0;
        wb(1'b1, emu_probe_pkg::OFS_CTRL, 32'h20);
        settle(3);
        chk("stall", 32'h1, 32'(stall_o));
        chk("ready held", 32'h0, 32'(cpu_ready_o));
        chk("grant", 32'h0, 32'(cop_grant_o));
        chk("emulating", 32'h0, 32'(emulating_o));
        chk("mem timeout", 32'h0, 32'(mem_timeout_en_o));
        @(posedge clock_i);
        ce_i           <= 1'b0;
        sync_start_n_i <= 1'b1;
        settle(5);
        chk("frozen stall", 32'h1, 32'(stall_o));
        @(posedge clock_i);
        ce_i <= 1'b1;
        for (i = 0; i < 10 && stall_o !== 1'b0; i++) @(negedge clock_i);
        chk("stall", 32'h0, 32'(stall_o));
        chk("grant", 32'h1, 32'(cop_grant_o));
        chk("emulating", 32'h1, 32'(emulating_o));
        rd(emu_probe_pkg::OFS_IRQ_STAT, 32'h2);
        wb(1'b1, emu_probe_pkg::OFS_IRQ_MASK, 32'h6);
        settle(0);
        chk("irq", 32'h1, 32'(irq_o));
        wb(1'b1, emu_probe_pkg::OFS_IRQ_STAT, 32'h2);
        settle(0);
        chk("irq", 32'h0, 32'(irq_o));
        wb(1'b1, emu_probe_pkg::OFS_CTRL, 32'h30);
        cop_exc_i <= 1'b1;
        settle(4);
        chk("cop exc", 32'h1, 32'(cop_exc_o));
        chk("irq", 32'h1, 32'(irq_o));
        wb(1'b1, emu_probe_pkg::OFS_CTRL, 32'h22);
        cop_exc_i <= 1'b0;
        settle(2);
        chk("cop exc", 32'h0, 32'(cop_exc_o));
        $display("test sync done");
        @(posedge clock_i);
        nmi_i <= 1'b1;
        settle(8);
        chk("nmi step", 32'h0, 32'(serve_nmi_o));
        wb(1'b1, emu_probe_pkg::OFS_CTRL, 32'h20);
        nmi_i <= 1'b0;
        settle(4);
        chk("nmi step", 32'h0, 32'(serve_nmi_o));
        @(posedge clock_i);
        nmi_i  <= 1'b1;
        intr_i <= 1'b1;
        for (i = 0; i < 10 && serve_intr_o !== 1'b1; i++) @(negedge clock_i);
        chk("serve", 32'h1, {30'h0, serve_nmi_o, serve_intr_o});
        @(posedge clock_i);
        nmi_i  <= 1'b0;
        intr_i <= 1'b0;
        for (i = 0; i < 3; i++) begin
            pulse(i);
            chk("serve", 32'(i == 0 ? 2 : i == 1), {30'h0, serve_nmi_o, serve_intr_o});
        end
        $display("test interrupt done");
        for (i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            exp_a = (i == 0) ? 20'h0FFFF : {seed[15:0], 4'h0} + {4'h0, seed[31:16]};
            exp_a = exp_a + 20'h1;
            @(posedge clock_i);
            seg_i       <= (i == 0) ? 16'h0 : seed[15:0];
            off_i       <= (i == 0) ? 16'hFFFF : seed[31:16];
            next_addr_i <= seed[19:0];
            addr_load_i <= 1'b1;
            @(posedge clock_i);
            addr_load_i <= 1'b0;
            addr_inc_i  <= 1'b1;
            @(posedge clock_i);
            addr_inc_i  <= 1'b0;
            settle(0);
            chk("trace", 32'(exp_a), 32'(trace_addr_o));
            chk("wrap", 32'(off_i == 16'hFFFF), 32'(wrap_mismatch_o));
        end
        $display("test trace done");
        wb(1'b1, emu_probe_pkg::OFS_BRK_ADDR, 32'(exp_a));
        wb(1'b1, emu_probe_pkg::OFS_CTRL, 32'h28);
        combined_i <= 1'b1;
        pulse(3);
        chk("break", 32'h0, 32'(break_o));
        @(posedge clock_i);
        combined_i <= 1'b0;
        pulse(3);
        chk("break", 32'h1, 32'(break_o));
        rd(emu_probe_pkg::OFS_NEXT_ADDR, 32'(next_addr_i));
        rd(emu_probe_pkg::OFS_LAST_ADDR, 32'(exp_a));
        pulse(4);
        chk("break", 32'h1, 32'(break_o));
        $display("test break done");
        test_done();
    end
endmodule
`default_nettype wire
